//--- core/prmc_ctrl.sv
// module: host side read controller for a page mode mask rom
`timescale 1ns/1ps
// What this block does
// - chip select is held high from reset and through the whole wait phase.
// - after reset chip select stays high for at least 200 ns before any access.
// - requests are accepted only after the power-up wait has run out.
// - during the wait address, gate and width pins may sit at any level.
// - the short page time is used only for in-page changes of an open selected page.
// - the width select changes only on reset and at the edge that takes chip select and gate active.
// - width select high means word mode, low means byte mode.
module prmc_ctrl
  import prmc_pkg::*;
#(
  parameter logic [1:0] GATE_OPT  = GATE_ACTIVE_LOW,
  parameter int unsigned PAGE_BYTES = 8
)(
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         req_valid_i,
  output logic                              req_ready_o,
  input  wire logic [prmc_pkg::BYTE_ADDR_W-1:0] req_addr_i,
  input  wire logic                         req_word_i,
  output logic                              rsp_valid_o,
  output logic [prmc_pkg::DATA_W-1:0]       rsp_data_o,
  output logic                              rom_cs_n_o,
  output logic                              rom_gate_o,
  output logic                              rom_word_o,
  output logic [prmc_pkg::ADDR_W-1:0]       rom_addr_o,
  input  wire logic [prmc_pkg::DATA_W-1:0]  rom_data_i,
  output logic                              rom_top_o,
  output logic                              rom_top_oe_n_o
);
  import prmc_pkg::*;

  localparam int unsigned PAGE_LSB = (PAGE_BYTES == 16) ? 4 : 3;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic gate_level(input logic act);
    unique case (GATE_OPT)
      GATE_ACTIVE_HIGH: gate_level = act;
      GATE_ACTIVE_LOW:  gate_level = !act;
      default:          gate_level = 1'b0;
    endcase
  endfunction

  // page part of a request address, split
  // a word address has no top pin bit, so its page starts one bit lower
  function automatic logic [BYTE_ADDR_W-1:0] page_of(input logic [BYTE_ADDR_W-1:0] a,
                                                    input logic                   w);
    page_of = w ? (a >> (PAGE_LSB - 1)) : (a >> PAGE_LSB);
  endfunction

  // ---------------------------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] din_s1_r;
  logic [DATA_W-1:0] din_s2_r;
  logic [DATA_W-1:0] din_s3_r;
  always_ff @(posedge clk_i)
  begin
    din_s1_r <= rom_data_i;
    din_s2_r <= din_s1_r;
    din_s3_r <= din_s2_r;
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  prmc_state_e                state_r;
  prmc_state_e                state_nxt;
  logic                       word_r;
  logic                       word_nxt;
  logic                       open_r;
  logic                       open_nxt;
  logic [BYTE_ADDR_W-1:0]     addr_r;
  logic [BYTE_ADDR_W-1:0]     addr_nxt;
  logic [DATA_W-1:0]          data_r;
  logic [DATA_W-1:0]          data_nxt;
  logic                       rsp_r;
  logic                       rsp_nxt;
  logic                       tm_load;
  logic [CNT_W-1:0]           tm_value;
  logic                       tm_done;
  logic                       same_page;
  logic                       accept;
  logic                       data_agree;
  logic                       wait_start_r;

  prmc_timer u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (tm_load),
    .value_i (tm_value),
    .done_o  (tm_done)
  );

  // a width change closes the page and reselects
  assign same_page   = open_r && (req_word_i == word_r) &&
                       (page_of(req_addr_i, word_r) == page_of(addr_r, word_r));
  // data counts once the last two stages agree on the bits in use
  assign data_agree  = word_r ? (din_s2_r == din_s3_r) :
                       (din_s2_r[LOW_DATA_W-1:0] == din_s3_r[LOW_DATA_W-1:0]);
  assign req_ready_o = (state_r == PRMC_IDLE) ||
                       ((state_r == PRMC_OPEN) && (!req_valid_i || same_page));
  assign accept      = req_valid_i && req_ready_o;

  always_comb
  begin
    state_nxt = state_r;
    word_nxt  = word_r;
    open_nxt  = open_r;
    addr_nxt  = addr_r;
    data_nxt  = data_r;
    rsp_nxt   = 1'b0;
    tm_load   = 1'b0;
    tm_value  = '0;
    unique case (state_r)
      PRMC_WAIT:
      begin
        // other pins ignored
        // wait count loads in the first cycle after reset
        tm_load   = wait_start_r;
        tm_value  = CNT_W'(PWRUP_WAIT_CYC);
        if (tm_done)
        begin
          state_nxt = PRMC_IDLE;
        end
      end
      PRMC_IDLE:
      begin
        if (accept)
        begin
          word_nxt  = req_word_i;
          addr_nxt  = req_addr_i;
          open_nxt  = 1'b1;
          tm_load   = 1'b1;
          // full access plus synchroniser delay
          tm_value  = CNT_W'(ACC_CYC + 3);
          state_nxt = PRMC_ACCESS;
        end
      end
      PRMC_OPEN:
      begin
        if (accept)
        begin
          addr_nxt  = req_addr_i;
          tm_load   = 1'b1;
          tm_value  = CNT_W'(PAGE_ACC_CYC + 3);
          state_nxt = PRMC_ACCESS;
        end
        else if (req_valid_i)
        begin
          open_nxt  = 1'b0;
          tm_load   = 1'b1;
          tm_value  = CNT_W'(RELEASE_CYC);
          state_nxt = PRMC_RELEASE;
        end
      end
      PRMC_ACCESS:
      begin
        if (tm_done && data_agree)
        begin
          data_nxt  = word_r ? din_s3_r : {{(DATA_W-LOW_DATA_W){1'b0}}, din_s3_r[LOW_DATA_W-1:0]};
          rsp_nxt   = 1'b1;
          state_nxt = PRMC_OPEN;
        end
      end
      PRMC_RELEASE:
      begin
        if (tm_done)
        begin
          state_nxt = PRMC_IDLE;
        end
      end
      default:
      begin
        state_nxt = PRMC_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= PRMC_WAIT;
      word_r  <= 1'b1;
      open_r  <= 1'b0;
      addr_r  <= '0;
      data_r  <= '0;
      rsp_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      word_r  <= word_nxt;
      open_r  <= open_nxt;
      addr_r  <= addr_nxt;
      data_r  <= data_nxt;
      rsp_r   <= rsp_nxt;
    end
  end

  // power-up wait start: timer loads in the first cycle after reset
  always_ff @(posedge clk_i)
  begin
    wait_start_r <= rst_i;
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  logic selected;
  assign selected = (state_r == PRMC_ACCESS) || (state_r == PRMC_OPEN);
  assign rom_cs_n_o     = !selected;
  assign rom_gate_o     = gate_level(selected);
  assign rom_word_o     = word_r;
  assign rom_addr_o     = word_r ? addr_r[ADDR_W-1:0] : addr_r[BYTE_ADDR_W-1:1];
  // top pin driven only in byte mode
  assign rom_top_o      = addr_r[0];
  assign rom_top_oe_n_o = word_r;
  assign rsp_valid_o    = rsp_r;
  assign rsp_data_o     = data_r;
endmodule // prmc_ctrl

//--- core/prmc_pkg.sv
// package: pin timing and layout constants for the page rom read controller
package prmc_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  // ---------------------------------------------------------------
  // pin layout
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W          = 22;
  localparam int unsigned BYTE_ADDR_W     = 23;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned LOW_DATA_W      = 8;
  localparam int unsigned TOP_BIT         = 15;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned PWRUP_WAIT_NS   = 200;
  localparam int unsigned PWRUP_WAIT_CYC  = (PWRUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACC_NS          = 120;
  localparam int unsigned ACC_CYC         = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PAGE_ACC_NS     = 25;
  localparam int unsigned PAGE_ACC_CYC    = (PAGE_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WIDTH_ACC_NS    = 120;
  localparam int unsigned WIDTH_ACC_CYC   = (WIDTH_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RELEASE_NS      = 25;
  localparam int unsigned RELEASE_CYC     = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 4;
  // ---------------------------------------------------------------
  // output gate polarity options
  // ---------------------------------------------------------------
  localparam logic [1:0]  GATE_ACTIVE_LOW     = 2'h0;
  localparam logic [1:0]  GATE_ACTIVE_HIGH    = 2'h1;
  localparam logic [1:0]  GATE_IGNORED_OPTION = 2'h2;
  typedef enum logic [2:0] {PRMC_WAIT, PRMC_IDLE, PRMC_OPEN, PRMC_ACCESS,
                            PRMC_RELEASE} prmc_state_e;
endpackage

//--- core/prmc_timer.sv
// module: loadable down counter for wait intervals
`timescale 1ns/1ps
module prmc_timer
  import prmc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              load_i,
  input  wire logic [CNT_W-1:0]  value_i,
  output logic                   done_o
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (load_i)
    begin
      cnt_nxt = value_i;
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_o = (cnt_r == '0) && !load_i;
endmodule // prmc_timer

//--- tb/prmc_rom_model.sv
// model: page rom device answering the controller pins
`timescale 1ns/1ps
module prmc_rom_model
  import prmc_pkg::*;
#(
  parameter logic [1:0]  GATE_OPT   = GATE_ACTIVE_LOW,
  parameter int unsigned PAGE_BYTES = 8
)(
  input  wire logic              cs_n_i,
  input  wire logic              gate_i,
  input  wire logic              word_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              top_i,
  output logic      [DATA_W-1:0] data_o
);
  localparam int LOW = (PAGE_BYTES == 16) ? 3 : 2;
  realtime     t_full = 0;
  realtime     t_page = 0;
  logic [15:0] w;
  logic        on;
  logic        ok;
  assign on = !cs_n_i && (GATE_OPT == GATE_IGNORED_OPTION || gate_i == GATE_OPT[0]);
  assign w  = {addr_i[7:0] ^ 8'h5A, addr_i[15:8] ^ addr_i[21:14]};
  always @(cs_n_i or word_i or addr_i[21:LOW]) t_full = $realtime;
  always @(on or addr_i[LOW-1:0] or (top_i & !word_i)) t_page = $realtime;
  initial data_o = 16'h0000;
  always #5
  begin
    ok = on && $realtime >= t_full + ACC_NS && $realtime >= t_page + PAGE_ACC_NS;
    if (!on) data_o = ~data_o;
    else if (word_i) data_o = ok ? w : ~w;
    else data_o = {~data_o[15:8], ok ? (top_i ? w[15:8] : w[7:0]) : ~w[7:0]};
  end
endmodule // prmc_rom_model

//--- tb/prmc_ctrl_sva.sv
// checker: pin protocol assertions for the rom read controller
`timescale 1ns/1ps
module prmc_ctrl_sva
  import prmc_pkg::*;
#(
  parameter logic [1:0]  GATE_OPT   = GATE_ACTIVE_LOW,
  parameter int unsigned PAGE_BYTES = 8
)(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              req_valid_i,
  input wire logic              req_ready_o,
  input wire logic              rsp_valid_o,
  input wire logic [DATA_W-1:0] rsp_data_o,
  input wire logic              rom_cs_n_o,
  input wire logic              rom_gate_o,
  input wire logic              rom_word_o,
  input wire logic [ADDR_W-1:0] rom_addr_o,
  input wire logic              rom_top_oe_n_o
);
  localparam int LOW = (PAGE_BYTES == 16) ? 3 : 2;
  logic gate_on;
  assign gate_on = (GATE_OPT == GATE_IGNORED_OPTION) || (rom_gate_o == GATE_OPT[0]);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_select;
    $fell(rom_cs_n_o);
  endsequence
  sequence s_settle;
    !rsp_valid_o [*3] ##[1:6] rsp_valid_o;
  endsequence
  a_wait_cs_high: assert property ($fell(rst_i) |-> (rom_cs_n_o && !req_ready_o) [*3])
    else $error("chip select wait cut short");
  a_select_after_take: assert property (s_select |->
    $past(req_valid_i && req_ready_o) || $past(req_valid_i && req_ready_o, 2))
    else $error("chip select fell without a request");
  a_full_access: assert property (s_select |-> s_settle)
    else $error("answer outside full access window");
  a_inpage_access: assert property ($changed(rom_addr_o) && !rom_cs_n_o
    && $past(!rom_cs_n_o) |-> !rsp_valid_o [*3])
    else $error("page answer too early");
  a_page_upper_hold: assert property (!rom_cs_n_o && $past(!rom_cs_n_o)
    |-> $stable(rom_addr_o >> LOW))
    else $error("upper address moved while selected");
  a_word_frees_top: assert property (rom_word_o |-> rom_top_oe_n_o)
    else $error("top pin driven in word mode");
  a_byte_drives_top: assert property (!rom_word_o && !rom_cs_n_o |-> !rom_top_oe_n_o)
    else $error("top pin not driven in byte mode");
  a_width_switch: assert property ($changed(rom_word_o) |-> !rom_cs_n_o && gate_on)
    else $error("width changed while not active");
  a_byte_upper_zero: assert property (rsp_valid_o && !rom_word_o |-> rsp_data_o[15:8] == 8'h00)
    else $error("upper byte not cleared");
  a_rsp_selected: assert property (rsp_valid_o |-> $past(!rom_cs_n_o && gate_on, 2))
    else $error("data taken while outputs off");
endmodule // prmc_ctrl_sva
bind prmc_ctrl prmc_ctrl_sva #(.GATE_OPT(GATE_OPT), .PAGE_BYTES(PAGE_BYTES)) i_prmc_ctrl_sva (
  .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rom_cs_n_o(rom_cs_n_o),
  .rom_gate_o(rom_gate_o), .rom_word_o(rom_word_o), .rom_addr_o(rom_addr_o),
  .rom_top_oe_n_o(rom_top_oe_n_o));

//--- tb/test_prmc_ctrl.sv
// bench: directed reads through the rom read controller
`timescale 1ns/1ps
module test_prmc_ctrl;
  import prmc_pkg::*;
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   req_valid_i = 1'b0;
  logic                   req_word_i = 1'b0;
  logic [BYTE_ADDR_W-1:0] req_addr_i = 23'h2AAAAA;
  logic                   req_ready_o, rsp_valid_o, rom_cs_n_o, rom_gate_o;
  logic                   rom_word_o, rom_top_o, rom_top_oe_n_o;
  logic [DATA_W-1:0]      rsp_data_o, rom_q, rom_bus;
  logic [ADDR_W-1:0]      rom_addr_o;
  int error_cnt = 0;
  int checks_done = 0;
  int cs_rises = 0;
  assign rom_bus = {rom_top_oe_n_o ? rom_q[15] : rom_top_o, rom_q[14:0]};
  always @(posedge rom_cs_n_o) cs_rises++;
  initial forever #50 clk_i = ~clk_i;
  prmc_ctrl #(.GATE_OPT(GATE_ACTIVE_HIGH), .PAGE_BYTES(8)) i_prmc_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_addr_i(req_addr_i), .req_word_i(req_word_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .rom_cs_n_o(rom_cs_n_o), .rom_gate_o(rom_gate_o),
    .rom_word_o(rom_word_o), .rom_addr_o(rom_addr_o), .rom_data_i(rom_bus),
    .rom_top_o(rom_top_o), .rom_top_oe_n_o(rom_top_oe_n_o));
  prmc_rom_model #(.GATE_OPT(GATE_ACTIVE_HIGH), .PAGE_BYTES(8)) i_prmc_rom_model (
    .cs_n_i(rom_cs_n_o), .gate_i(rom_gate_o), .word_i(rom_word_o), .addr_i(rom_addr_o),
    .top_i(rom_bus[15]), .data_o(rom_q));
  task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin error_cnt++; $display("BAD %0t data %h exp %h", $time, got, exp); end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin error_cnt++; $display("BAD %0t flag %b exp %b", $time, got, exp); end
  endtask
  task automatic rd(input logic [22:0] a, input logic w);
    int n;
    logic [15:0] c;
    n = 0;
    c = w ? {a[7:0] ^ 8'h5A, a[15:8] ^ a[21:14]} : {a[8:1] ^ 8'h5A, a[16:9] ^ a[22:15]};
    @(posedge clk_i);
    req_addr_i <= a;
    req_word_i <= w;
    req_valid_i <= 1'b1;
    do @(negedge clk_i); while (req_ready_o !== 1'b1 && ++n < 40);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    do @(negedge clk_i); while (rsp_valid_o !== 1'b1 && ++n < 80);
    cmp_flag(n < 80, 1'b1);
    cmp_data(rsp_data_o, w ? c : {8'h00, a[0] ? c[15:8] : c[7:0]});
    cmp_flag(rom_gate_o, 1'b1);
    cmp_flag(rom_word_o, w);
    cmp_flag(rom_cs_n_o, 1'b0);
  endtask
  task automatic t_power;
    repeat (PWRUP_WAIT_CYC + 1)
    begin
      @(negedge clk_i);
      cmp_flag(rom_cs_n_o, 1'b1);
      cmp_flag(req_ready_o, 1'b0);
    end
    $display("test power-up wait done");
  endtask
  task automatic t_word_page;
    int r;
    rd(23'h000120, 1'b1);
    r = cs_rises;
    rd(23'h000121, 1'b1);
    rd(23'h000123, 1'b1);
    cmp_flag(cs_rises == r, 1'b1);
    rd(23'h000124, 1'b1);
    cmp_flag(cs_rises == r + 1, 1'b1);
    $display("test word page done");
  endtask
  task automatic t_byte;
    rd(23'h000246, 1'b0);
    rd(23'h000247, 1'b0);
    rd(23'h000241, 1'b0);
    $display("test byte page done");
  endtask
  task automatic t_miss;
    int r;
    r = cs_rises;
    rd(23'h000248, 1'b0);
    rd(23'h000124, 1'b1);
    cmp_flag(cs_rises > r, 1'b1);
    rd(23'h7FFFFF, 1'b0);
    rd(23'h3FFFFF, 1'b1);
    $display("test page miss done");
  endtask
  task automatic t_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    req_valid_i <= 1'b1;
    t_power();
    rd(23'h000120, 1'b1);
    $display("test mid-run reset done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_power();
    t_word_page();
    t_byte();
    t_miss();
    t_reset();
    report_and_stop();
  end
  initial
  begin
    #(3000 * 100);
    error_cnt++;
    report_and_stop();
  end
endmodule // test_prmc_ctrl
